/* File: core/epp_pkg.sv */
package epp_pkg;

  // ---------------------------------------------------------------
  // timing, in oscillator periods of the device clock
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_HOLD_TOSC   = 80;
  localparam int unsigned ALE_WIDTH_TOSC   = 180;
  localparam int unsigned ALE_TO_PROGRAM_STROBE_TOSC = 250;
  localparam int unsigned PROGRAM_STROBE_WIDTH_TOSC  = 250;
  localparam int unsigned DATA_HOLD_TOSC   = 30;
  localparam int unsigned PROGRAM_STROBE_TO_ALE_TOSC = 600;
  localparam int unsigned READ_VALID_TOSC  = 100;
  localparam int unsigned RESET_WAIT_TOSC  = 2000;
  localparam int unsigned SETTLE_TOSC      = 100;

  // ---------------------------------------------------------------
  // oscillator divider: 100 MHz system clock, 6 MHz device oscillator
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned OSC_HZ      = 6_000_000;
  localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;
  localparam int unsigned OSC_DIV_W   = 5;
  localparam int unsigned CNT_W       = 12;

  localparam logic [15:0] RESERVED_FILL = 16'hFFFF;

  typedef enum logic [1:0] {
    EPP_OP_PROGRAM = 2'h0,
    EPP_OP_VERIFY  = 2'h1,
    EPP_OP_DUMP    = 2'h2
  } epp_op_t;

  typedef struct packed {
    epp_op_t     op;
    logic        reserved;
    logic [15:0] addr;
    logic [15:0] data;
  } epp_req_t;

  typedef struct packed {
    logic        external_access_mode_input;
    logic        vpp_enable;
    logic        device_reset_n;
    logic        address_latch_strobe;
    logic        program_strobe_n;
  } epp_ctrl_t;

endpackage : epp_pkg

/* File: core/epp_osc_tick.sv */
`timescale 1ns/1ps
// one-cycle enable per device oscillator period
module epp_osc_tick #(
  parameter int unsigned DIV = epp_pkg::OSC_DIV
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      tick_o
);

  logic [epp_pkg::OSC_DIV_W-1:0] cnt_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (cnt_reg == epp_pkg::OSC_DIV_W'(DIV - 1)) begin
      cnt_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o  <= 1'b0;
    end
  end

endmodule : epp_osc_tick

/* File: core/epp_programmer.sv */
`timescale 1ns/1ps
// Function
// - address or command valid no later than strobe falling edge.
// - hold address or command at least 80 oscillator periods after strobe falls.
// - data word present no later than program strobe falls.
// - hold program data 30 oscillator periods after program strobe rises.
// - wait 600 oscillator periods after program strobe rises before next latch.
// - sample read-back data no earlier than 100 periods after program strobe falls.
// - wait 2000 periods after reset release before first latch strobe.
// - program all-ones to reserved addresses.
// - raise external access mode input before programming supply enable.
// - hold reset until oscillator and supplies have settled.
// - power-up order: strobes high, select valid, mode, supply, settle, reset.
module epp_programmer #(
  parameter logic [3:0] SLAVE_ID = 4'h0,
  parameter logic [3:0] MODE_SEL = 4'h5
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              start_i,
  input  wire epp_pkg::epp_req_t req_i,
  input  wire logic [15:0]       port_in_i,
  output epp_pkg::epp_ctrl_t     ctrl_o,
  output logic [3:0]             slave_identifier_o,
  output logic [3:0]             programming_mode_select_o,
  output logic [15:0]            port_out_o,
  output logic                   port_oe_o,
  output logic                   osc_en_o,
  output logic                   ready_o,
  output logic                   done_o,
  output logic [15:0]            rdata_o
);

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [10:0] {
    S_CLK    = 11'h001,
    S_PINS   = 11'h002,
    S_MODE   = 11'h004,
    S_VPP    = 11'h008,
    S_SETTLE = 11'h010,
    S_RSTW   = 11'h020,
    S_IDLE   = 11'h040,
    S_ALE    = 11'h080,
    S_GAP    = 11'h100,
    S_PROGRAM_STROBE   = 11'h200,
    S_HOLD   = 11'h400
  } epp_state_t;

  localparam logic [epp_pkg::CNT_W-1:0] C_HOLD  = epp_pkg::CNT_W'(epp_pkg::ALE_WIDTH_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_GAP   = epp_pkg::CNT_W'(epp_pkg::ALE_TO_PROGRAM_STROBE_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_PW    = epp_pkg::CNT_W'(epp_pkg::PROGRAM_STROBE_WIDTH_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_RD    = epp_pkg::CNT_W'(epp_pkg::READ_VALID_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_NEXT  = epp_pkg::CNT_W'(epp_pkg::PROGRAM_STROBE_TO_ALE_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_RST   = epp_pkg::CNT_W'(epp_pkg::RESET_WAIT_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_SET   = epp_pkg::CNT_W'(epp_pkg::SETTLE_TOSC);
  localparam logic [epp_pkg::CNT_W-1:0] C_STEP  = 12'h001;

  epp_state_t                  state_reg;
  logic [epp_pkg::CNT_W-1:0]   cnt_reg;
  logic                        tick;
  epp_pkg::epp_req_t           req_reg;
  logic                        is_read;
  logic                        start_pend_reg;

  epp_osc_tick u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_o  (tick)
  );

  assign is_read = (req_reg.op != epp_pkg::EPP_OP_PROGRAM);

  // ---------------------------------------------------------------
  // sequencer; counts advance only on oscillator ticks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= S_CLK;
      cnt_reg   <= '0;
    end else if (tick) begin
      case (state_reg)
        S_CLK:    state_reg <= S_PINS;
        S_PINS:   state_reg <= S_MODE;
        S_MODE:   state_reg <= S_VPP;
        S_VPP: begin
          state_reg <= S_SETTLE;
          cnt_reg   <= '0;
        end
        S_SETTLE: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_SET - C_STEP) begin
            state_reg <= S_RSTW;
            cnt_reg   <= '0;
          end
        end
        S_RSTW: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_RST - C_STEP) begin
            state_reg <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (start_pend_reg) begin
            state_reg <= S_ALE;
            cnt_reg   <= '0;
          end
        end
        S_ALE: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_HOLD - C_STEP) begin
            state_reg <= S_GAP;
            cnt_reg   <= '0;
          end
        end
        S_GAP: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_GAP - C_STEP) begin
            state_reg <= S_PROGRAM_STROBE;
            cnt_reg   <= '0;
          end
        end
        S_PROGRAM_STROBE: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_PW - C_STEP) begin
            state_reg <= S_HOLD;
            cnt_reg   <= '0;
          end
        end
        S_HOLD: begin
          cnt_reg <= cnt_reg + C_STEP;
          if (cnt_reg == C_NEXT - C_STEP) begin
            state_reg <= S_IDLE;
          end
        end
        default:  state_reg <= S_CLK;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // request capture; a start is remembered until the idle tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_pend_reg <= 1'b0;
      req_reg        <= '0;
    end else if (start_i && ready_o && !start_pend_reg) begin
      start_pend_reg <= 1'b1;
      req_reg        <= req_i;
      if (req_i.reserved && req_i.op == epp_pkg::EPP_OP_PROGRAM) begin
        req_reg.data <= epp_pkg::RESERVED_FILL;
      end
    end else if (tick && state_reg == S_IDLE) begin
      start_pend_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_o                    <= '0;
      slave_identifier_o        <= '0;
      programming_mode_select_o <= '0;
      osc_en_o                  <= 1'b0;
    end else begin
      osc_en_o <= 1'b1;
      ctrl_o.device_reset_n <= !(state_reg inside {S_CLK, S_PINS, S_MODE, S_VPP, S_SETTLE});
      if (state_reg != S_CLK) begin
        ctrl_o.program_strobe_n   <= (state_reg != S_PROGRAM_STROBE);
        ctrl_o.address_latch_strobe <= (state_reg != S_ALE);
        slave_identifier_o        <= SLAVE_ID;
        programming_mode_select_o <= MODE_SEL;
      end
      ctrl_o.external_access_mode_input <= !(state_reg inside {S_CLK, S_PINS});
      ctrl_o.vpp_enable <= !(state_reg inside {S_CLK, S_PINS, S_MODE});
    end
  end

  // address through the latch; data from the gap, kept one tick extra as strobes lag state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_out_o <= '0;
      port_oe_o  <= 1'b0;
    end else begin
      if (state_reg == S_IDLE && tick && start_pend_reg) begin
        port_out_o <= req_reg.addr;
        port_oe_o  <= 1'b1;
      end else if (state_reg == S_GAP) begin
        port_out_o <= req_reg.data;
        port_oe_o  <= !is_read;
      end else if (state_reg == S_HOLD && tick &&
                   cnt_reg == epp_pkg::CNT_W'(epp_pkg::DATA_HOLD_TOSC)) begin
        port_oe_o  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // completion and read-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
      done_o  <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      done_o  <= tick && state_reg == S_HOLD && cnt_reg == C_NEXT - C_STEP;
      ready_o <= (state_reg == S_IDLE) && !start_pend_reg && !(start_i && ready_o);
      if (tick && state_reg == S_PROGRAM_STROBE && is_read && cnt_reg == C_RD) begin
        rdata_o <= port_in_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // clock ages of the program strobe; they saturate so long idle stretches never wrap
  localparam logic [15:0] HOLD_CLKS = 16'(epp_pkg::DATA_HOLD_TOSC * epp_pkg::OSC_DIV);
  localparam logic [15:0] NEXT_CLKS = 16'(epp_pkg::PROGRAM_STROBE_TO_ALE_TOSC * epp_pkg::OSC_DIV);
  localparam logic [15:0] PW_CLKS   = 16'((epp_pkg::PROGRAM_STROBE_WIDTH_TOSC + 1) * epp_pkg::OSC_DIV);
  logic [15:0]            rise_age_reg;
  logic [15:0]            low_age_reg;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_age_reg <= '1;
      low_age_reg  <= '0;
    end else begin
      rise_age_reg <= ctrl_o.program_strobe_n ? rise_age_reg + {15'h0000, ~&rise_age_reg} : '0;
      low_age_reg  <= ctrl_o.program_strobe_n ? '0 : low_age_reg + {15'h0000, ~&low_age_reg};
    end
  end

  property p_vpp_after_mode;
    $rose(ctrl_o.vpp_enable) |-> ctrl_o.external_access_mode_input;
  endproperty
  a_vpp_after_mode: assert property (p_vpp_after_mode) else $error("vpp before mode");

  property p_reset_after_vpp;
    $rose(ctrl_o.device_reset_n) |-> ctrl_o.vpp_enable && ctrl_o.program_strobe_n;
  endproperty
  a_reset_after_vpp: assert property (p_reset_after_vpp) else $error("reset early");

  property p_strobes_high_at_mode;
    $rose(ctrl_o.external_access_mode_input) |->
      ctrl_o.address_latch_strobe && ctrl_o.program_strobe_n;
  endproperty
  a_strobes_high_at_mode: assert property (p_strobes_high_at_mode) else $error("strobe low");

  property p_addr_stable;
    $fell(ctrl_o.address_latch_strobe) |-> $stable(port_out_o) [*8];
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");

  property p_data_setup;
    $fell(ctrl_o.program_strobe_n) && req_reg.op == epp_pkg::EPP_OP_PROGRAM |->
      port_oe_o && port_out_o == req_reg.data;
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data not set up");

  property p_data_hold;
    ctrl_o.device_reset_n && ctrl_o.program_strobe_n && rise_age_reg < HOLD_CLKS &&
      req_reg.op == epp_pkg::EPP_OP_PROGRAM |-> port_oe_o;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data dropped");

  property p_reserved_fill;
    $fell(ctrl_o.program_strobe_n) && req_reg.reserved &&
      req_reg.op == epp_pkg::EPP_OP_PROGRAM |-> port_out_o == epp_pkg::RESERVED_FILL;
  endproperty
  a_reserved_fill: assert property (p_reserved_fill) else $error("reserved not ones");

  property p_program_strobe_bounded;
    ctrl_o.device_reset_n && !ctrl_o.program_strobe_n |-> low_age_reg < PW_CLKS;
  endproperty
  a_program_strobe_bounded: assert property (p_program_strobe_bounded) else $error("program_strobe pulse too long");

  property p_gap_after_program_strobe;
    ctrl_o.device_reset_n && ctrl_o.program_strobe_n && rise_age_reg < NEXT_CLKS |->
      ctrl_o.address_latch_strobe;
  endproperty
  a_gap_after_program_strobe: assert property (p_gap_after_program_strobe) else $error("latch too soon");

  c_program:  cover property (done_o && req_reg.op == epp_pkg::EPP_OP_PROGRAM);
  c_verify:   cover property (done_o && req_reg.op == epp_pkg::EPP_OP_VERIFY);
  c_dump:     cover property (done_o && req_reg.op == epp_pkg::EPP_OP_DUMP);
  c_reserved: cover property (done_o && req_reg.reserved);

endmodule : epp_programmer

/* File: dv/epp_dev_model.sv */
`timescale 1ns/1ps
// ------------------------------
// device side of the port
// ------------------------------
module epp_dev_model (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire epp_pkg::epp_ctrl_t ctrl_i,
  input  wire logic [15:0]        port_out_i,
  input  wire logic               port_oe_i,
  input  wire logic               osc_en_i,
  output logic [15:0]             port_in_o,
  output logic [7:0]              viol_o
);
  localparam int D = epp_pkg::OSC_DIV;
  logic [15:0]        mem [logic [15:0]];
  epp_pkg::epp_ctrl_t p;
  logic [15:0]        addr;
  logic [15:0]        wdata;
  logic [15:0]        word;
  logic               wr;
  logic               seen_rise;
  logic               seen_latch;
  int                 n_rst;
  int                 n_low;
  int                 n_rise;
  int                 n_latch;

  function automatic logic [15:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction : rd

  // counters are in clocks; the first edge that sees an event counts as 1
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      p = '0;
      n_rst = 0;
      n_low = 0;
      n_rise = 0;
      n_latch = 0;
      seen_rise = 1'b0;
      seen_latch = 1'b0;
      wr = 1'b0;
      addr = 16'h0000;
      wdata = 16'h0000;
      viol_o = 8'h00;
      port_in_o <= 16'hFFFF;
    end else begin
      n_rst++;
      n_low++;
      n_rise++;
      n_latch++;
      if (ctrl_i.vpp_enable && !p.vpp_enable && !ctrl_i.external_access_mode_input) viol_o++;
      if (ctrl_i.device_reset_n && !p.device_reset_n) begin
        n_rst = 1;
        if (!(ctrl_i.external_access_mode_input && ctrl_i.vpp_enable && osc_en_i &&
              ctrl_i.address_latch_strobe && ctrl_i.program_strobe_n)) viol_o++;
      end
      if (ctrl_i.device_reset_n && !ctrl_i.address_latch_strobe && p.address_latch_strobe) begin
        if (!seen_latch && n_rst <= 2000 * D) viol_o++;
        if (seen_rise && n_rise <= 600 * D) viol_o++;
        if (!port_oe_i) viol_o++;
        addr = port_out_i;
        n_latch = 1;
        seen_latch = 1'b1;
      end else if (seen_latch && n_latch <= 80 * D && (!port_oe_i || port_out_i !== addr)) begin
        viol_o++;
      end
      if (ctrl_i.device_reset_n && !ctrl_i.program_strobe_n && p.program_strobe_n) begin
        wr = port_oe_i;
        wdata = port_out_i;
        n_low = 1;
      end
      if (ctrl_i.device_reset_n && !ctrl_i.program_strobe_n && n_low > 744 * D) viol_o++;
      if (ctrl_i.device_reset_n && ctrl_i.program_strobe_n && !p.program_strobe_n) begin
        if (n_low <= 250 * D) viol_o++;
        if (wr) mem[addr] = wdata;
        n_rise = 1;
        seen_rise = 1'b1;
      end else if (wr && seen_rise && n_rise <= 30 * D && (!port_oe_i || port_out_i !== wdata)) begin
        viol_o++;
      end
      word = rd(addr);
      // before the valid point the port shows the inverse, so an early sample fails
      port_in_o <= (!ctrl_i.program_strobe_n && !wr && n_low >= 100 * D - 1) ? word : ~word;
      p = ctrl_i;
    end
  end
endmodule : epp_dev_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
// ------------------------------
// programming port bench
// ------------------------------
module tb;
  localparam logic [3:0] SLAVE_IDENTIFIER  = 4'h3;
  localparam logic [3:0] MSEL = 4'hA;
  logic               clk_i;
  logic               reset_i;
  logic               start_i;
  epp_pkg::epp_req_t  req_i;
  logic [15:0]        port_in;
  epp_pkg::epp_ctrl_t ctrl;
  logic [3:0]         slave_identifier;
  logic [3:0]         msel;
  logic [15:0]        port_out;
  logic               port_oe;
  logic               osc_en;
  logic               ready;
  logic               done;
  logic [15:0]        rdata;
  logic [7:0]         viol;
  int                 n_mismatch;
  int                 cmp_count;

  epp_programmer #(.SLAVE_ID(SLAVE_IDENTIFIER), .MODE_SEL(MSEL)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .req_i(req_i),
    .port_in_i(port_in), .ctrl_o(ctrl), .slave_identifier_o(slave_identifier),
    .programming_mode_select_o(msel), .port_out_o(port_out), .port_oe_o(port_oe),
    .osc_en_o(osc_en), .ready_o(ready), .done_o(done), .rdata_o(rdata)
  );

  epp_dev_model i_dev (
    .clk_i(clk_i), .reset_i(reset_i), .ctrl_i(ctrl), .port_out_i(port_out),
    .port_oe_i(port_oe), .osc_en_i(osc_en), .port_in_o(port_in), .viol_o(viol)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_for(input logic on_ready, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(negedge clk_i);
      if (on_ready ? ready === 1'b1 : done === 1'b1) return;
    end
    check(16'h0000, 16'h0001);
    final_report();
  endtask : wait_for

  // every operation also carries a stray request while busy, which must be ignored
  task automatic run_op(input epp_pkg::epp_op_t op, input logic rsv, input logic [15:0] a,
                        input logic [15:0] d);
    wait_for(1'b1, 100);
    req_i = '{op: op, reserved: rsv, addr: a, data: d};
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    check({15'h0000, ready}, 16'h0000);
    req_i = '{op: epp_pkg::EPP_OP_PROGRAM, reserved: 1'b0, addr: 16'h2200, data: 16'h0001};
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    wait_for(1'b0, 25000);
    @(negedge clk_i);
    check({15'h0000, done}, 16'h0000);
  endtask : run_op

  task automatic t_power_up;
    check({10'h000, ctrl, port_oe}, 16'h0000);
    reset_i = 1'b0;
    wait_for(1'b1, 60000);
    check({11'h000, ctrl}, 16'h001F);
    check({8'h00, slave_identifier, msel}, {8'h00, SLAVE_IDENTIFIER, MSEL});
    check({15'h0000, osc_en}, 16'h0001);
  endtask : t_power_up

  task automatic t_program_strobe_reserved;
    run_op(epp_pkg::EPP_OP_PROGRAM, 1'b1, 16'h2018, 16'h1234);
    check(i_dev.rd(16'h2018), 16'hFFFF);
    check(16'(i_dev.mem.exists(16'h2200)), 16'h0000);
  endtask : t_program_strobe_reserved

  task automatic t_verify;
    run_op(epp_pkg::EPP_OP_VERIFY, 1'b0, 16'h2018, 16'h0000);
    check(rdata, 16'hFFFF);
  endtask : t_verify

  task automatic t_dump;
    run_op(epp_pkg::EPP_OP_PROGRAM, 1'b0, 16'h2100, 16'h5A3C);
    check(i_dev.rd(16'h2100), 16'h5A3C);
    run_op(epp_pkg::EPP_OP_DUMP, 1'b0, 16'h2100, 16'h0000);
    check(rdata, 16'h5A3C);
    check({8'h00, viol}, 16'h0000);
  endtask : t_dump

  initial begin
    reset_i = 1'b1;
    start_i = 1'b0;
    req_i = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk_i);
    t_power_up();
    t_program_strobe_reserved();
    t_verify();
    t_dump();
    final_report();
  end
endmodule : tb
